// [svs_pkg.sv]
// package: register map, field layout and reset values of the supply voltage sensor
package svs_pkg;

	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] OFF_ENABLE_CONTROL = 3'h0;
	localparam logic [2:0] OFF_CONDITION_STATUS = 3'h1;
	localparam logic [2:0] OFF_INTERRUPT_ENABLE = 3'h2;
	localparam logic [2:0] OFF_INTERRUPT_FLAGS = 3'h3;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int BIT_BATT_LEVEL_SENSE_EN = 0;
	localparam int BIT_BATT_ADC_CONNECT_EN = 1;
	localparam int BIT_SUPPLY_LEVEL_SENSE_EN = 2;
	localparam int BIT_SUPPLY_ADC_CONNECT_EN = 3;
	localparam int BIT_LOW_SEL_LO = 4;
	localparam int BIT_LOW_SEL_HI = 5;
	localparam int BIT_HIGH_THRESHOLD_SELECT = 6;
	localparam logic [7:0] CTRL_IMPL_MASK = 8'h7F;

	// ----------------------------------------------------------------
	// status, enable and flag fields (same layout)
	// ----------------------------------------------------------------
	localparam int BIT_LOW = 0;
	localparam int BIT_HIGH = 1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] IRQ_EN_RESET = 2'h0;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

// [svs_event_latch.sv]
// module: synchronises the comparator outputs and latches change events into w1c flags
`timescale 1ns/100ps

module svs_event_latch (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// comparator levels from the analog side
	input wire logic [1:0] cond_async,
	// sensing enabled; events are masked while off
	input wire logic sense_on,
	// software clear, one bit per flag
	input wire logic [1:0] clear,
	// results
	output logic [1:0] cond,
	output logic [1:0] flags
);

	logic [1:0] sync1_reg, sync1_next;
	logic [1:0] cond_reg, cond_next;
	logic [1:0] last_reg, last_next;
	logic [1:0] flags_reg, flags_next;
	logic [1:0] change;

	always_comb begin
		sync1_next = cond_async;
		cond_next = sync1_reg;
		last_next = cond_reg;
		// only the second stage feeds the edge detector, never the possibly metastable first
		// comparator output is meaningless while the divider is open
		change = sense_on ? (cond_reg ^ last_reg) : 2'h0;
		// set wins over a clear in the same cycle
		flags_next = (flags_reg & ~clear) | change; // R12
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_reg <= 2'h0;
			cond_reg <= 2'h0;
			last_reg <= 2'h0;
			flags_reg <= svs_pkg::FLAGS_RESET;
		end else begin
			sync1_reg <= sync1_next;
			cond_reg <= cond_next;
			last_reg <= last_next;
			flags_reg <= flags_next;
		end
	end

	assign cond = cond_reg;
	assign flags = flags_reg;

	property p_change_sets_flag;
		@(posedge clk) disable iff (!nrst)
		(sense_on && (cond_reg[1] != last_reg[1])) |=> flags_reg[1];
	endproperty
	a_change_sets_flag: assert property (p_change_sets_flag) // R12
		else $error("high condition change did not set its flag");

	property p_low_change_sets_flag;
		@(posedge clk) disable iff (!nrst)
		(sense_on && (cond_reg[0] != last_reg[0])) |=> flags_reg[0];
	endproperty
	a_low_change_sets_flag: assert property (p_low_change_sets_flag) // R12
		else $error("low condition change did not set its flag");

	property p_clear_only_by_write;
		@(posedge clk) disable iff (!nrst)
		($past(flags_reg[0]) && !flags_reg[0]) |-> $past(clear[0]);
	endproperty
	a_clear_only_by_write: assert property (p_clear_only_by_write) // R12
		else $error("low flag fell without a clear");

endmodule

// [svs_supply_sense.sv]
// module: supply voltage sensor control, register file and interrupt
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps

// Summary of operation
// R1: run mode closes battery divider if its level-sense or ADC enable is set.
// R2: run mode closes supply divider if its level-sense or ADC enable is set.
// R3: with both level-sense enables, comparator takes the battery-sense pin.
// R4: with both ADC enables, ADC takes divided battery-sense voltage.
// R5: stop mode opens both dividers and disables level sensing.
// R6: stop mode leaves configuration register contents untouched.
// R7: four registers decoded at offsets 0x0 to 0x3.
// R8: one selected voltage drives comparator producing low and high events.
// R9: at most one voltage routed to the ADC at once.
// R10: setting battery level-sense clears supply level-sense; supply sets only if clear.
// R11: setting battery ADC enable clears supply ADC enable.
// R12: each flag set on change of its condition, cleared by writing one.
// R13: interrupt requested while a flag is set with its enable.
// R14: unimplemented bits and reserved offsets read zero, ignore writes.

module svs_supply_sense #(
	parameter int ADDR_W = svs_pkg::ADDR_W,
	parameter int DATA_W = svs_pkg::DATA_W
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// register port
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [DATA_W-1:0] RDATA,
	// system power mode
	input wire logic STOP_MODE,
	// analog comparator outcomes (asynchronous)
	input wire logic HIGH_VOLTAGE_CONDITION_IN,
	input wire logic LOW_VOLTAGE_CONDITION_IN,
	// analog path controls
	output logic BATT_PATH_CLOSE,
	output logic SUPPLY_PATH_CLOSE,
	output logic CMP_SELECT_BATT,
	output logic CMP_ENABLE,
	output logic ADC_SELECT_BATT,
	output logic ADC_SELECT_SUPPLY,
	output logic HIGH_THRESHOLD_SELECT,
	output logic [1:0] LOW_THRESHOLD_SELECT,
	// interrupt
	output logic IRQ
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0] ctrl_reg, ctrl_next;
	logic [1:0] irq_en_reg, irq_en_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic stop_s1_reg, stop_s1_next;
	logic stop_reg, stop_next;
	logic batt_path_reg, batt_path_next;
	logic supply_path_reg, supply_path_next;
	logic cmp_batt_reg, cmp_batt_next;
	logic cmp_en_reg, cmp_en_next;
	logic adc_batt_reg, adc_batt_next;
	logic adc_supply_reg, adc_supply_next;
	logic high_sel_reg, high_sel_next;
	logic [1:0] low_sel_reg, low_sel_next;
	logic irq_reg, irq_next;
	logic [1:0] flag_clear;
	logic [1:0] cond;
	logic [1:0] flags;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	// ----------------------------------------------------------------
	// control register write with precedence
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] w;
		w = WDATA[7:0] & svs_pkg::CTRL_IMPL_MASK; // R14
		ctrl_next = ctrl_reg;
		irq_en_next = irq_en_reg;
		flag_clear = 2'h0;
		// stop mode never touches these, so settings resume afterwards
		if (WR && hit(ADDR, svs_pkg::OFF_ENABLE_CONTROL)) begin // R7 R6
			if (w[svs_pkg::BIT_BATT_LEVEL_SENSE_EN])
				w[svs_pkg::BIT_SUPPLY_LEVEL_SENSE_EN] = 1'b0; // R10
			if (w[svs_pkg::BIT_BATT_ADC_CONNECT_EN])
				w[svs_pkg::BIT_SUPPLY_ADC_CONNECT_EN] = 1'b0; // R11
			ctrl_next = w;
		end
		if (WR && hit(ADDR, svs_pkg::OFF_INTERRUPT_ENABLE)) begin // R7
			irq_en_next = WDATA[1:0];
		end
		if (WR && hit(ADDR, svs_pkg::OFF_INTERRUPT_FLAGS)) begin // R7
			flag_clear = WDATA[1:0]; // R12
		end
	end

	// ----------------------------------------------------------------
	// read mux, answer in the following cycle
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = '0;
		if (RD) begin
			if (hit(ADDR, svs_pkg::OFF_ENABLE_CONTROL))
				rdata_next = DATA_W'(ctrl_reg);
			else if (hit(ADDR, svs_pkg::OFF_CONDITION_STATUS))
				rdata_next = DATA_W'(cond);
			else if (hit(ADDR, svs_pkg::OFF_INTERRUPT_ENABLE))
				rdata_next = DATA_W'(irq_en_reg);
			else if (hit(ADDR, svs_pkg::OFF_INTERRUPT_FLAGS))
				rdata_next = DATA_W'(flags);
			else
				rdata_next = DATA_W'(svs_pkg::READ_ZERO); // R14
		end
	end

	// ----------------------------------------------------------------
	// analog path steering
	// ----------------------------------------------------------------
	always_comb begin
		logic bls, bae, sls, sae;
		bls = ctrl_reg[svs_pkg::BIT_BATT_LEVEL_SENSE_EN];
		bae = ctrl_reg[svs_pkg::BIT_BATT_ADC_CONNECT_EN];
		sls = ctrl_reg[svs_pkg::BIT_SUPPLY_LEVEL_SENSE_EN];
		sae = ctrl_reg[svs_pkg::BIT_SUPPLY_ADC_CONNECT_EN];
		stop_s1_next = STOP_MODE;
		stop_next = stop_s1_reg;
		batt_path_next = !stop_reg && (bls || bae); // R1 R5
		supply_path_next = !stop_reg && (sls || sae); // R2 R5
		cmp_en_next = !stop_reg && (bls || sls); // R5 R8
		cmp_batt_next = bls; // R3
		adc_batt_next = !stop_reg && bae; // R4 R9
		adc_supply_next = !stop_reg && sae && !bae; // R4 R9
		high_sel_next = ctrl_reg[svs_pkg::BIT_HIGH_THRESHOLD_SELECT];
		low_sel_next = ctrl_reg[svs_pkg::BIT_LOW_SEL_HI:svs_pkg::BIT_LOW_SEL_LO];
		irq_next = |(flags & irq_en_reg); // R13
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			ctrl_reg <= svs_pkg::CTRL_RESET;
			irq_en_reg <= svs_pkg::IRQ_EN_RESET;
			rdata_reg <= '0;
			stop_s1_reg <= 1'b0;
			stop_reg <= 1'b0;
			batt_path_reg <= 1'b0;
			supply_path_reg <= 1'b0;
			cmp_batt_reg <= 1'b0;
			cmp_en_reg <= 1'b0;
			adc_batt_reg <= 1'b0;
			adc_supply_reg <= 1'b0;
			high_sel_reg <= 1'b0;
			low_sel_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			irq_en_reg <= irq_en_next;
			rdata_reg <= rdata_next;
			stop_s1_reg <= stop_s1_next;
			stop_reg <= stop_next;
			batt_path_reg <= batt_path_next;
			supply_path_reg <= supply_path_next;
			cmp_batt_reg <= cmp_batt_next;
			cmp_en_reg <= cmp_en_next;
			adc_batt_reg <= adc_batt_next;
			adc_supply_reg <= adc_supply_next;
			high_sel_reg <= high_sel_next;
			low_sel_reg <= low_sel_next;
			irq_reg <= irq_next;
		end
	end

	// ----------------------------------------------------------------
	// comparator events
	// ----------------------------------------------------------------
	svs_event_latch u_events (
		.clk(CLK),
		.nrst(NRST),
		.cond_async({HIGH_VOLTAGE_CONDITION_IN, LOW_VOLTAGE_CONDITION_IN}),
		.sense_on(cmp_en_reg), // R8
		.clear(flag_clear),
		.cond(cond),
		.flags(flags)
	);

	assign RDATA = rdata_reg;
	assign BATT_PATH_CLOSE = batt_path_reg;
	assign SUPPLY_PATH_CLOSE = supply_path_reg;
	assign CMP_SELECT_BATT = cmp_batt_reg;
	assign CMP_ENABLE = cmp_en_reg;
	assign ADC_SELECT_BATT = adc_batt_reg;
	assign ADC_SELECT_SUPPLY = adc_supply_reg;
	assign HIGH_THRESHOLD_SELECT = high_sel_reg;
	assign LOW_THRESHOLD_SELECT = low_sel_reg;
	assign IRQ = irq_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_batt_path;
		@(posedge CLK) disable iff (!NRST)
		##1 batt_path_reg == (!$past(stop_reg) && ($past(ctrl_reg[0]) || $past(ctrl_reg[1])));
	endproperty
	a_batt_path: assert property (p_batt_path) // R1
		else $error("battery divider path wrong");

	property p_supply_path;
		@(posedge CLK) disable iff (!NRST)
		(!stop_reg && (ctrl_reg[2] || ctrl_reg[3])) |=> supply_path_reg;
	endproperty
	a_supply_path: assert property (p_supply_path) // R2
		else $error("supply divider path not closed");

	property p_cmp_prec;
		@(posedge CLK) disable iff (!NRST)
		ctrl_reg[0] |=> CMP_SELECT_BATT;
	endproperty
	a_cmp_prec: assert property (p_cmp_prec) // R3
		else $error("comparator not on battery-sense pin");

	property p_adc_prec;
		@(posedge CLK) disable iff (!NRST)
		(!stop_reg && ctrl_reg[1]) |=> (ADC_SELECT_BATT && !ADC_SELECT_SUPPLY);
	endproperty
	a_adc_prec: assert property (p_adc_prec) // R4
		else $error("adc precedence broken");

	property p_stop_open;
		@(posedge CLK) disable iff (!NRST)
		STOP_MODE [*3] |=> !BATT_PATH_CLOSE && !SUPPLY_PATH_CLOSE && !CMP_ENABLE;
	endproperty
	a_stop_open: assert property (p_stop_open) // R5
		else $error("paths not open in stop mode");

	property p_ctrl_kept;
		@(posedge CLK) disable iff (!NRST)
		!(WR && ADDR == ADDR_W'(svs_pkg::OFF_ENABLE_CONTROL)) |=> $stable(ctrl_reg);
	endproperty
	a_ctrl_kept: assert property (p_ctrl_kept) // R6
		else $error("control changed without a write");

	property p_adc_one;
		@(posedge CLK) disable iff (!NRST)
		!(ADC_SELECT_BATT && ADC_SELECT_SUPPLY);
	endproperty
	a_adc_one: assert property (p_adc_one) // R9
		else $error("two voltages on adc");

	property p_excl;
		@(posedge CLK) disable iff (!NRST)
		!(ctrl_reg[0] && ctrl_reg[2]) && !(ctrl_reg[1] && ctrl_reg[3]);
	endproperty
	a_excl: assert property (p_excl) // R10
		else $error("both enables of a pair set");

	property p_irq;
		@(posedge CLK) disable iff (!NRST)
		##1 IRQ == |($past(flags) & $past(irq_en_reg));
	endproperty
	a_irq: assert property (p_irq) // R13
		else $error("interrupt level wrong");

	property p_rsvd;
		@(posedge CLK) disable iff (!NRST)
		(RD && ADDR > ADDR_W'(svs_pkg::OFF_INTERRUPT_FLAGS)) |=> RDATA == '0;
	endproperty
	a_rsvd: assert property (p_rsvd) // R14 R7
		else $error("reserved offset read nonzero");

	property p_supply_adc;
		@(posedge CLK) disable iff (!NRST)
		(!stop_reg && ctrl_reg[svs_pkg::BIT_SUPPLY_ADC_CONNECT_EN]
			&& !ctrl_reg[svs_pkg::BIT_BATT_ADC_CONNECT_EN]) |=> ADC_SELECT_SUPPLY;
	endproperty
	a_supply_adc: assert property (p_supply_adc) // R4
		else $error("supply adc path not connected");

	property p_stop_adc;
		@(posedge CLK) disable iff (!NRST)
		STOP_MODE [*3] |=> !ADC_SELECT_BATT && !ADC_SELECT_SUPPLY;
	endproperty
	a_stop_adc: assert property (p_stop_adc) // R5
		else $error("adc still connected in stop mode");

	property p_ctrl_read;
		@(posedge CLK) disable iff (!NRST)
		(RD && ADDR == ADDR_W'(svs_pkg::OFF_ENABLE_CONTROL)) |=> RDATA == DATA_W'($past(ctrl_reg));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) // R7
		else $error("control read data wrong");

	property p_rdata_idle;
		@(posedge CLK) disable iff (!NRST)
		!RD |=> RDATA == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // R7
		else $error("read data not zero outside a read");

	property p_ctrl_unimpl;
		@(posedge CLK) disable iff (!NRST)
		(ctrl_reg & ~svs_pkg::CTRL_IMPL_MASK) == 8'h00;
	endproperty
	a_ctrl_unimpl: assert property (p_ctrl_unimpl) // R14
		else $error("unimplemented control bit set");

endmodule

// [svs_analog_model.sv]
// model of the analog comparator behind the sensor's path controls
`timescale 1ns/100ps

module svs_analog_model (
	// path controls from the block
	input wire logic cmp_enable,
	// levels the bench sets on the sensed pin
	input wire logic hi_lvl,
	input wire logic lo_lvl,
	// comparator outcomes
	output logic high_cond,
	output logic low_cond
);
	// an unpowered comparator reports no condition
	assign high_cond = cmp_enable & hi_lvl;
	assign low_cond = cmp_enable & lo_lvl;
endmodule

// [test_supply_voltage_sense_ctrl.sv]
// bench for the supply voltage sensor control block
`timescale 1ns/100ps

`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, sn); end end

module test_supply_voltage_sense_ctrl;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic stop = 1'b0;
	logic hi_lvl = 1'b0;
	logic lo_lvl = 1'b0;
	logic hcond, lcond, bpc, spc, csb, cen, asb, ass, hts, irq;
	logic [1:0] lts;
	logic [7:0] rdata;
	int err_total = 0;
	int compares = 0;

	always #20 clk = ~clk;

	svs_supply_sense i_svs_supply_sense (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .STOP_MODE(stop),
		.HIGH_VOLTAGE_CONDITION_IN(hcond), .LOW_VOLTAGE_CONDITION_IN(lcond),
		.BATT_PATH_CLOSE(bpc), .SUPPLY_PATH_CLOSE(spc), .CMP_SELECT_BATT(csb),
		.CMP_ENABLE(cen), .ADC_SELECT_BATT(asb), .ADC_SELECT_SUPPLY(ass),
		.HIGH_THRESHOLD_SELECT(hts), .LOW_THRESHOLD_SELECT(lts), .IRQ(irq));

	svs_analog_model i_svs_analog_model (.cmp_enable(cen), .hi_lvl(hi_lvl), .lo_lvl(lo_lvl),
		.high_cond(hcond), .low_cond(lcond));

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] ex);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", ex, rdata)
	endtask

	// outputs follow the control register one cycle later
	task automatic chk_path(input logic [4:0] ex);
		repeat (2) @(posedge clk);
		#1;
		`CHK("paths", ex, {bpc, spc, cen, asb, ass})
	endtask

	task automatic wait_irq(input logic ex);
		int n;
		#1;
		for (n = 0; n < 12 && irq !== ex; n++) begin
			@(posedge clk);
			#1;
		end
		`CHK("irq", ex, irq)
		if (irq !== ex) begin
			give_verdict();
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_map();
		for (int i = 0; i < 8; i++) begin
			wr_reg(3'(i), (i == 0 || i == 2) ? 8'h00 : 8'hFF);
			rd_chk(3'(i), 8'h00);
		end
		$display("test reset_map done");
	endtask

	task automatic t_control();
		wr_reg(3'h0, 8'hFF);
		rd_chk(3'h0, 8'h73);
		chk_path(5'b10110);
		`CHK("cmp_sel", 1'b1, csb)
		`CHK("thresholds", 3'h7, {hts, lts})
		wr_reg(3'h0, 8'h0C);
		rd_chk(3'h0, 8'h0C);
		chk_path(5'b01101);
		`CHK("cmp_sel", 1'b0, csb)
		wr_reg(3'h0, 8'h08);
		chk_path(5'b01001);
		$display("test control done");
	endtask

	task automatic t_stop();
		wr_reg(3'h0, 8'h0C);
		@(posedge clk);
		stop <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		`CHK("stop_paths", 5'b00000, {bpc, spc, cen, asb, ass})
		rd_chk(3'h0, 8'h0C);
		@(posedge clk);
		stop <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		`CHK("run_paths", 5'b01101, {bpc, spc, cen, asb, ass})
		$display("test stop done");
	endtask

	task automatic t_events();
		wr_reg(3'h0, 8'h01);
		wr_reg(3'h2, 8'h02);
		rd_chk(3'h2, 8'h02);
		@(posedge clk);
		hi_lvl <= 1'b1;
		wait_irq(1'b1);
		rd_chk(3'h1, 8'h02);
		rd_chk(3'h3, 8'h02);
		wr_reg(3'h2, 8'h01);
		lo_lvl <= 1'b1;
		repeat (6) @(posedge clk);
		rd_chk(3'h3, 8'h03);
		wr_reg(3'h3, 8'h03);
		wait_irq(1'b0);
		rd_chk(3'h3, 8'h00);
		@(posedge clk);
		hi_lvl <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		`CHK("masked_irq", 1'b0, irq)
		wr_reg(3'h2, 8'h03);
		wait_irq(1'b1);
		wr_reg(3'h3, 8'h02);
		wait_irq(1'b0);
		$display("test events done");
	endtask

	// ----------------------------------------------------------------
	// sequence and verdict
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset_map();
		t_control();
		t_stop();
		t_events();
		give_verdict();
	end
endmodule
